// ==== rtl/bridge_reset_power_control.sv ====
// reset, power state and hot-swap indicator control for a two-port bridge
`timescale 1ns/100ps
`include "bridge_rst_regs.svh"

// What this block does
// [R01] drive enumeration event output on insertion or pending extraction
// [R02] drive removal-ready LED output showing insertion and removal status
// [R03] entering D3hot with clock control enabled stops secondary clocks low
// [R04] writes requesting D1 or D2 are ignored; state is unchanged
// [R05] D3hot to D0 restarts clocks, internal reset, no secondary reset
// [R06] leaving power-off state only through full power-up reset from system
// [R07] power management event signals are never forwarded through the block
// [R08] primary reset floats interface signals and loads register defaults
// [R09] primary reset is asynchronous; no access answered during it
// [R10] stay inaccessible 16 clocks after primary reset release
// [R11] secondary reset held for whole primary reset, released after it
// [R12] secondary reset bit holds secondary reset until written clear
// [R13] secondary reset floats secondary control signals and grants
// [R14] secondary address/data, command/byte enables, parity driven low
// [R15] secondary reset flushes posted write and delayed buffers
// [R16] secondary reset from the bit leaves configuration access open
// [R17] chip reset resets state, floats signals, sets secondary reset bit
// [R18] chip reset bit self-clears within 20 clocks after release write
// [R19] no accesses answered while the chip reset is in progress; here only during its pulse, the hold phase answers
// [R20] power state encoding: D0 is 00, D3hot is 11
module bridge_reset_power_control #(
  parameter int SEC_CLK_COUNT = 5,
  parameter int AD_WIDTH      = 32
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     reset_n_in,
  // register bus, avalon-mm slave
  input  wire logic [3:0]               avs_address_in,
  input  wire logic                     avs_read_in,
  input  wire logic                     avs_write_in,
  input  wire logic [31:0]              avs_writedata_in,
  output logic      [31:0]              avs_readdata_out,
  output logic                          avs_waitrequest_out,
  // board strap and hot-swap events
  input  wire logic                     bus_power_clock_ctl_enable_in,
  input  wire logic                     board_inserted_in,
  input  wire logic                     extract_request_in,
  input  wire logic                     clock_mask_loaded_in,
  // forwarding datapath toward the secondary bus
  input  wire logic [AD_WIDTH-1:0]      fwd_addr_data_in,
  input  wire logic [3:0]               fwd_cmd_byte_en_n_in,
  input  wire logic                     fwd_parity_in,
  input  wire logic                     fwd_drive_in,
  // hot-swap pins
  output logic                          enum_event_n_out,
  output logic                          removal_ready_led_out,
  // resets, floats and flushes
  output logic                          secondary_reset_n_out,
  output logic                          primary_oe_n_out,
  output logic                          secondary_ctl_oe_n_out,
  output logic                          buffer_flush_out,
  // secondary datapath pins
  output logic [AD_WIDTH-1:0]           secondary_addr_data_out,
  output logic [3:0]                    secondary_cmd_byte_en_n_out,
  output logic                          secondary_parity_out,
  output logic                          secondary_data_oe_n_out,
  output logic [SEC_CLK_COUNT-1:0]      secondary_clock_outputs_out
);

  // power management event pins have no port here: they bypass the bridge
  // [R07]
  // a power-off state is left only via reset_n_in from the system [R06]

  logic [1:0]                   rst_sync_q;
  logic                         rst_n;
  logic [4:0]                   post_cnt_q;
  logic                         post_busy_q;
  bridge_rst_pkg::chip_state_t  chip_q;
  logic [4:0]                   chip_cnt_q;
  logic                         chip_keep_sec_q;
  logic                         sec_bit_q;
  logic                         chip_bit_q;
  bridge_rst_pkg::pwr_state_t   pwr_q;
  logic                         enum_pending_q;
  logic                         led_on_q;
  logic                         clk_stop_q;
  logic                         div_q;
  logic                         wait_q;
  logic [31:0]                  rdata_q;
  logic                         soft_rst;
  logic                         access_ok;
  logic                         req;
  logic                         wr_go;
  logic                         sec_rst_act;
  logic [31:0]                  rd_mux;
  logic                         pwr_wr_ok;
  logic                         wake_req;
  logic [1:0]                   pwr_wdata;

  // reset release through two flops; assertion stays asynchronous [R09]
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rst_sync_q <= `SYNC_RESET;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // blackout window after primary reset release [R10]
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      post_cnt_q  <= 5'h00;
      post_busy_q <= 1'b1;
    end
    else if (post_busy_q)
    begin
      post_cnt_q  <= post_cnt_q + 5'h01;
      post_busy_q <= (post_cnt_q != (`POST_RESET_CLKS - 5'h01)); // [R10]
    end
  end

  assign soft_rst  = (chip_q == bridge_rst_pkg::CHIP_PULSE);
  // the hold phase must stay open, or software could never clear the bit
  assign access_ok = !post_busy_q && !soft_rst; // [R19] [R16]
  assign req       = avs_read_in || avs_write_in;
  assign wr_go     = avs_write_in && !wait_q;
  assign pwr_wdata = avs_writedata_in[`PWR_MSB:`PWR_LSB];
  assign pwr_wr_ok = wr_go && (avs_address_in == `OFS_POWER_CTL)
                     && (pwr_wdata == bridge_rst_pkg::PWR_D0
                         || pwr_wdata == bridge_rst_pkg::PWR_D3HOT); // [R04]
  assign wake_req  = pwr_wr_ok && (pwr_q == bridge_rst_pkg::PWR_D3HOT)
                     && (pwr_wdata == bridge_rst_pkg::PWR_D0); // [R05]

  // chip reset sequencer: short blind pulse, then hold until released
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_q          <= bridge_rst_pkg::CHIP_IDLE;
      chip_cnt_q      <= 5'h00;
      chip_keep_sec_q <= 1'b0;
    end
    else
    begin
      unique case (chip_q)
        bridge_rst_pkg::CHIP_IDLE:
        begin
          chip_cnt_q <= 5'h00;
          if (wr_go && avs_address_in == `OFS_BRIDGE_CTL
              && avs_writedata_in[`BIT_CHIP_RESET])
          begin
            chip_q          <= bridge_rst_pkg::CHIP_PULSE; // [R17]
            chip_keep_sec_q <= 1'b1;
          end
          else if (wake_req)
          begin
            chip_q          <= bridge_rst_pkg::CHIP_PULSE; // [R05]
            chip_keep_sec_q <= 1'b0;
          end
        end
        bridge_rst_pkg::CHIP_PULSE:
        begin
          chip_cnt_q <= chip_cnt_q + 5'h01;
          if (chip_cnt_q == (`CHIP_PULSE_CLKS - 5'h01))
          begin
            chip_cnt_q <= 5'h00;
            chip_q     <= chip_keep_sec_q ? bridge_rst_pkg::CHIP_HOLD
                                          : bridge_rst_pkg::CHIP_IDLE;
          end
        end
        bridge_rst_pkg::CHIP_HOLD:
        begin
          // count only once secondary bit cleared and mask shifted in
          if (!sec_bit_q && clock_mask_loaded_in)
          begin
            chip_cnt_q <= chip_cnt_q + 5'h01;
            if (chip_cnt_q == (`CHIP_CLEAR_CLKS - 5'h01))
            begin
              chip_q          <= bridge_rst_pkg::CHIP_IDLE; // [R18]
              chip_keep_sec_q <= 1'b0;
            end
          end
        end
        default:
          chip_q <= bridge_rst_pkg::CHIP_IDLE;
      endcase
    end
  end

  // control bits; chip bit mirrors the sequencer, secondary bit software and the chip pulse
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_bit_q  <= 1'b0; // [R08]
      chip_bit_q <= 1'b0;
    end
    else
    begin
      chip_bit_q <= (chip_q != bridge_rst_pkg::CHIP_IDLE)
                    && !(chip_q == bridge_rst_pkg::CHIP_HOLD
                         && chip_cnt_q == (`CHIP_CLEAR_CLKS - 5'h01)
                         && !sec_bit_q && clock_mask_loaded_in); // [R18]
      if (soft_rst)
        sec_bit_q <= chip_keep_sec_q; // [R17] [R05]
      else if (wr_go && avs_address_in == `OFS_BRIDGE_CTL)
        sec_bit_q <= avs_writedata_in[`BIT_SEC_RESET]; // [R12]
    end
  end

  // power state; internal reset returns it to D0
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
      pwr_q <= bridge_rst_pkg::PWR_D0;
    else if (soft_rst)
      pwr_q <= bridge_rst_pkg::PWR_D0;
    else if (pwr_wr_ok)
      pwr_q <= bridge_rst_pkg::pwr_state_t'(pwr_wdata); // [R20] [R04]
  end

  // secondary clock gate, only with the strap enabled [R03]
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
      clk_stop_q <= 1'b0;
    else if (wake_req || soft_rst)
      clk_stop_q <= 1'b0; // [R05]
    else if (pwr_wr_ok && pwr_wdata == bridge_rst_pkg::PWR_D3HOT
             && pwr_q == bridge_rst_pkg::PWR_D0)
      clk_stop_q <= bus_power_clock_ctl_enable_in; // [R03]
  end

  // secondary clocks at half the primary rate, parked low when stopped
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 1'b0;
    else if (clk_stop_q)
      div_q <= 1'b0; // [R03]
    else
      div_q <= !div_q;
  end

  // one flop per clock pin so each pin has its own driver
  genvar gi;
  generate
    for (gi = 0; gi < SEC_CLK_COUNT; gi = gi + 1)
    begin : g_sclk
      always_ff @(posedge clk_sys_in or negedge rst_n)
      begin
        if (!rst_n)
          secondary_clock_outputs_out[gi] <= 1'b0;
        else
          secondary_clock_outputs_out[gi] <= !clk_stop_q && !div_q; // [R03]
      end
    end
  endgenerate

  // hot-swap: event pending is sticky, insertion wins over clear
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enum_pending_q <= 1'b0;
      led_on_q       <= 1'b0;
    end
    else if (soft_rst)
    begin
      enum_pending_q <= 1'b0;
      led_on_q       <= 1'b0;
    end
    else
    begin
      if (board_inserted_in || extract_request_in)
        enum_pending_q <= 1'b1; // [R01]
      else if (wr_go && avs_address_in == `OFS_HOTSWAP_CTL
               && avs_writedata_in[`BIT_ENUM_PENDING])
        enum_pending_q <= 1'b0;
      if (wr_go && avs_address_in == `OFS_HOTSWAP_CTL)
        led_on_q <= avs_writedata_in[`BIT_LED_ON]; // [R02]
    end
  end

  // hot-swap pins from flops
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enum_event_n_out      <= 1'b1;
      removal_ready_led_out <= 1'b0;
    end
    else
    begin
      enum_event_n_out      <= !enum_pending_q; // [R01]
      removal_ready_led_out <= led_on_q; // [R02]
    end
  end

  // secondary reset: bit, chip pulse, or chip hold until the mask is in
  assign sec_rst_act = sec_bit_q || (soft_rst && chip_keep_sec_q) ||
    (chip_q == bridge_rst_pkg::CHIP_HOLD && !clock_mask_loaded_in); // [R17]

  // reset, float and flush pins; flop reset value covers primary reset
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      secondary_reset_n_out  <= 1'b0; // [R11]
      primary_oe_n_out       <= 1'b1; // [R08]
      secondary_ctl_oe_n_out <= 1'b1; // [R08]
      buffer_flush_out       <= 1'b1; // [R15]
    end
    else
    begin
      secondary_reset_n_out  <= !sec_rst_act; // [R11] [R12] [R05]
      primary_oe_n_out       <= soft_rst; // [R17]
      secondary_ctl_oe_n_out <= sec_rst_act || soft_rst; // [R13] [R17]
      buffer_flush_out       <= sec_rst_act || soft_rst; // [R15] [R05]
    end
  end

  // secondary datapath pins: forced low and driven during secondary reset
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      secondary_addr_data_out     <= '0; // [R14]
      secondary_cmd_byte_en_n_out <= 4'h0;
      secondary_parity_out        <= 1'b0;
      secondary_data_oe_n_out     <= 1'b0;
    end
    else if (sec_rst_act)
    begin
      secondary_addr_data_out     <= '0; // [R14]
      secondary_cmd_byte_en_n_out <= 4'h0;
      secondary_parity_out        <= 1'b0;
      secondary_data_oe_n_out     <= 1'b0;
    end
    else
    begin
      secondary_addr_data_out     <= fwd_addr_data_in;
      secondary_cmd_byte_en_n_out <= fwd_cmd_byte_en_n_in;
      secondary_parity_out        <= fwd_parity_in;
      secondary_data_oe_n_out     <= soft_rst || !fwd_drive_in; // [R17]
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rd_mux = `WORD_ZERO;
    unique case (avs_address_in)
      `OFS_BRIDGE_CTL:
      begin
        rd_mux[`BIT_SEC_RESET]  = sec_bit_q;
        rd_mux[`BIT_CHIP_RESET] = chip_bit_q;
      end
      `OFS_POWER_CTL:
        rd_mux[`PWR_MSB:`PWR_LSB] = pwr_q; // [R20]
      `OFS_HOTSWAP_CTL:
      begin
        rd_mux[`BIT_ENUM_PENDING] = enum_pending_q;
        rd_mux[`BIT_LED_ON]       = led_on_q;
      end
      `OFS_STATUS:
      begin
        rd_mux[`BIT_ST_SEC_RST]     = sec_rst_act;
        rd_mux[`BIT_ST_CHIP_BUSY]   = chip_q != bridge_rst_pkg::CHIP_IDLE;
        rd_mux[`BIT_ST_D3HOT]       = pwr_q == bridge_rst_pkg::PWR_D3HOT;
        rd_mux[`BIT_ST_CLK_STOP]    = clk_stop_q;
        rd_mux[`BIT_ST_MASK_LOADED] = clock_mask_loaded_in;
      end
      default:
        rd_mux = `WORD_ZERO;
    endcase
  end

  // bus answer: waitrequest drops one cycle after the request is seen,
  // and stays high throughout any blackout so nothing is answered
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q  <= 1'b1; // [R09]
      rdata_q <= `WORD_ZERO;
    end
    else if (req && wait_q && access_ok)
    begin
      wait_q  <= 1'b0; // [R10] [R16] [R19]
      rdata_q <= rd_mux;
    end
    else
      wait_q <= 1'b1;
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out    = rdata_q;

endmodule

// ==== rtl/bridge_rst_pkg.sv ====
// types shared by the reset and power control block
package bridge_rst_pkg;

  // internal chip reset sequencer, one-hot
  typedef enum logic [2:0] {
    CHIP_IDLE  = 3'b001,
    CHIP_PULSE = 3'b010,
    CHIP_HOLD  = 3'b100
  } chip_state_t;

  // two-bit power state encoding
  typedef enum logic [1:0] {
    PWR_D0    = 2'b00,
    PWR_D1    = 2'b01,
    PWR_D2    = 2'b10,
    PWR_D3HOT = 2'b11
  } pwr_state_t;

endpackage

// ==== rtl/bridge_rst_regs.svh ====
// register offsets, field positions, reset values and cycle counts
`ifndef BRIDGE_RST_REGS_SVH
`define BRIDGE_RST_REGS_SVH

// byte offsets on the register bus
`define OFS_BRIDGE_CTL       4'h0
`define OFS_POWER_CTL        4'h4
`define OFS_HOTSWAP_CTL      4'h8
`define OFS_STATUS           4'hC

// bridge control fields
`define BIT_SEC_RESET        0
`define BIT_CHIP_RESET       1

// power control field
`define PWR_LSB              0
`define PWR_MSB              1

// hot-swap control fields
`define BIT_ENUM_PENDING     0
`define BIT_LED_ON           1

// status fields
`define BIT_ST_SEC_RST       0
`define BIT_ST_CHIP_BUSY     1
`define BIT_ST_D3HOT         2
`define BIT_ST_CLK_STOP      3
`define BIT_ST_MASK_LOADED   4

// cycle counts, in primary clocks
`define POST_RESET_CLKS      5'h10
`define CHIP_PULSE_CLKS      5'h10
`define CHIP_CLEAR_CLKS      5'h04
`define CHIP_CLEAR_MAX_CLKS  5'h14

`define WORD_ZERO            32'h0000_0000
`define SYNC_RESET           2'h0

`endif

// ==== verification/bridge_rst_properties.sv ====
// port-level checker for reset, float, flush and hot-swap behaviour
`timescale 1ns/100ps
`include "bridge_rst_regs.svh"
module bridge_rst_checker #(
  parameter int SEC_CLK_COUNT = 5,
  parameter int AD_WIDTH      = 32
) (
  input wire logic                clk_sys_in,
  input wire logic                reset_n_in,
  input wire logic [3:0]          avs_address_in,
  input wire logic                avs_write_in,
  input wire logic [31:0]         avs_writedata_in,
  input wire logic                avs_waitrequest_out,
  input wire logic                board_inserted_in,
  input wire logic                enum_event_n_out,
  input wire logic                removal_ready_led_out,
  input wire logic                secondary_reset_n_out,
  input wire logic                primary_oe_n_out,
  input wire logic                secondary_ctl_oe_n_out,
  input wire logic                buffer_flush_out,
  input wire logic [AD_WIDTH-1:0] secondary_addr_data_out,
  input wire logic [3:0]          secondary_cmd_byte_en_n_out,
  input wire logic                secondary_parity_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  // sixteen stalled cycles, built as two halves
  sequence s_wait16;
    avs_waitrequest_out[*8] ##1 avs_waitrequest_out[*8];
  endsequence
  // accepted write that turns the led on
  sequence s_led_write;
    avs_write_in && !avs_waitrequest_out &&
    avs_address_in == `OFS_HOTSWAP_CTL && avs_writedata_in[`BIT_LED_ON];
  endsequence
  // secondary reset seen on two samples, so a one-cycle lag is tolerated
  sequence s_srst_held;
    !secondary_reset_n_out && !$past(secondary_reset_n_out);
  endsequence

  a_rst_hold: assert property ($rose(reset_n_in) |->
    !secondary_reset_n_out)
    else $error("secondary reset released with primary reset");
  a_post_blackout: assert property ($rose(reset_n_in) |-> s_wait16)
    else $error("access answered inside post-reset blackout");
  a_float_no_ans: assert property (
    primary_oe_n_out && $past(primary_oe_n_out) |-> avs_waitrequest_out)
    else $error("access answered while primary pins float");
  a_sec_data_low: assert property (s_srst_held |->
    secondary_addr_data_out == '0 && secondary_cmd_byte_en_n_out == 4'h0 &&
    !secondary_parity_out)
    else $error("secondary datapath not low in secondary reset");
  a_sec_ctl_float: assert property (s_srst_held |->
    secondary_ctl_oe_n_out)
    else $error("secondary control driven in secondary reset");
  a_flush_on_srst: assert property (
    $fell(secondary_reset_n_out) |-> ##[0:1] buffer_flush_out)
    else $error("buffers not flushed on secondary reset");
  a_enum_event: assert property (
    $rose(board_inserted_in) |-> ##[1:2] !enum_event_n_out)
    else $error("insertion did not raise enumeration event");
  a_led_on: assert property (s_led_write |->
    ##[1:2] removal_ready_led_out)
    else $error("led did not follow register write");
  a_chip_pulse: assert property ($rose(primary_oe_n_out) |->
    primary_oe_n_out[*8] ##[1:12] !primary_oe_n_out)
    else $error("chip reset float pulse of wrong length");
endmodule

bind bridge_reset_power_control bridge_rst_checker #(
  .SEC_CLK_COUNT(SEC_CLK_COUNT), .AD_WIDTH(AD_WIDTH)) i_chk (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .board_inserted_in(board_inserted_in), .enum_event_n_out(enum_event_n_out),
  .removal_ready_led_out(removal_ready_led_out),
  .secondary_reset_n_out(secondary_reset_n_out),
  .primary_oe_n_out(primary_oe_n_out),
  .secondary_ctl_oe_n_out(secondary_ctl_oe_n_out),
  .buffer_flush_out(buffer_flush_out),
  .secondary_addr_data_out(secondary_addr_data_out),
  .secondary_cmd_byte_en_n_out(secondary_cmd_byte_en_n_out),
  .secondary_parity_out(secondary_parity_out));

// ==== verification/sec_side_model.sv ====
// far-side model: serial clock mask loader and forwarding datapath source
`timescale 1ns/100ps
module sec_side_model #(
  parameter int AD_WIDTH  = 32,
  parameter int MASK_CLKS = 3
) (
  input  wire logic                clk_sys_in,
  input  wire logic                reset_n_in,
  input  wire logic                mask_start_in,
  output logic                     clock_mask_loaded_out,
  output logic [AD_WIDTH-1:0]      fwd_addr_data_out,
  output logic [3:0]               fwd_cmd_byte_en_n_out,
  output logic                     fwd_parity_out,
  output logic                     fwd_drive_out
);
  int unsigned shift_cnt_q;

  // mask shifts in over a few clocks once started; lost on reset
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      shift_cnt_q           <= 0;
      clock_mask_loaded_out <= 1'b0;
    end
    else if (!mask_start_in)
    begin
      shift_cnt_q           <= 0;
      clock_mask_loaded_out <= 1'b0;
    end
    else
    begin
      shift_cnt_q           <= shift_cnt_q + 1;
      clock_mask_loaded_out <= (shift_cnt_q >= MASK_CLKS);
    end
  end

  // pattern flips every cycle; address/data alternates all ones and all zeros, so it reads zero every other cycle
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      fwd_addr_data_out     <= '1;
      fwd_cmd_byte_en_n_out <= 4'hA;
      fwd_parity_out        <= 1'b1;
      fwd_drive_out         <= 1'b0;
    end
    else
    begin
      fwd_addr_data_out     <= ~fwd_addr_data_out;
      fwd_cmd_byte_en_n_out <= ~fwd_cmd_byte_en_n_out;
      fwd_parity_out        <= ~fwd_parity_out;
      fwd_drive_out         <= 1'b1;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the reset and power control block
`timescale 1ns/100ps
`include "bridge_rst_regs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
  logic        clk_sys_in, reset_n_in, avs_read_in, avs_write_in;
  logic [3:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic        avs_waitrequest_out, strap, board_ev, extract_ev, mask_start;
  logic        mask_ok, fwd_par, fwd_drv, enum_n, led, srst_n, poe_n, coe_n;
  logic        flush, spar, doe_n;
  logic [31:0] fwd_ad, sad;
  logic [3:0]  fwd_cbe, scbe;
  logic [4:0]  sclk, prev;
  int          errors, checks, lat;
  time         t0;

  bridge_reset_power_control i_dut (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .bus_power_clock_ctl_enable_in(strap), .board_inserted_in(board_ev),
    .extract_request_in(extract_ev), .clock_mask_loaded_in(mask_ok),
    .fwd_addr_data_in(fwd_ad), .fwd_cmd_byte_en_n_in(fwd_cbe),
    .fwd_parity_in(fwd_par), .fwd_drive_in(fwd_drv),
    .enum_event_n_out(enum_n), .removal_ready_led_out(led),
    .secondary_reset_n_out(srst_n), .primary_oe_n_out(poe_n),
    .secondary_ctl_oe_n_out(coe_n), .buffer_flush_out(flush),
    .secondary_addr_data_out(sad), .secondary_cmd_byte_en_n_out(scbe),
    .secondary_parity_out(spar), .secondary_data_oe_n_out(doe_n),
    .secondary_clock_outputs_out(sclk));
  sec_side_model i_far (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .mask_start_in(mask_start), .clock_mask_loaded_out(mask_ok),
    .fwd_addr_data_out(fwd_ad), .fwd_cmd_byte_en_n_out(fwd_cbe),
    .fwd_parity_out(fwd_par), .fwd_drive_out(fwd_drv));

  // 50 MHz primary clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one avalon transfer; held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd);
    @(posedge clk_sys_in);
    avs_address_in   <= a;
    avs_writedata_in <= wd;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    lat = 0;
    do
    begin
      @(posedge clk_sys_in);
      lat++;
    end
    while (avs_waitrequest_out !== 1'b0 && lat < 400);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    if (lat >= 400)
    begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rd, exp)
  endtask

  // outputs read here are those settled just before the last edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // pulse an event input for one clock, then check the pending flag
  task automatic hs_event(input logic ins);
    board_ev   <= ins;
    extract_ev <= !ins;
    @(posedge clk_sys_in);
    board_ev   <= 1'b0;
    extract_ev <= 1'b0;
    cyc(3);
    `CHK(enum_n, 1'b0)
    rd_chk(`OFS_HOTSWAP_CTL, 32'h0000_0001);
    xfer(1'b1, `OFS_HOTSWAP_CTL, 32'h0000_0001);
    cyc(2);
    `CHK(enum_n, 1'b1)
  endtask

  task automatic clocks_run;
    cyc(1);
    prev = sclk;
    cyc(1);
    `CHK(prev ^ sclk, 5'h1F)
  endtask

  initial
  begin
    {reset_n_in, avs_read_in, avs_write_in, board_ev, extract_ev} = 5'h00;
    avs_address_in = 4'h0;
    avs_writedata_in = 32'h0000_0000;
    strap = 1'b1;
    mask_start = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    xfer(1'b0, `OFS_STATUS, 32'h0000_0000);
    `CHK(lat >= 16, 1'b1)
    `CHK(rd, 32'h0000_0000)
    rd_chk(`OFS_BRIDGE_CTL, 32'h0000_0000);
    rd_chk(`OFS_POWER_CTL, 32'h0000_0000);
    xfer(1'b1, 4'h2, 32'hFFFF_FFFF);
    rd_chk(4'h2, 32'h0000_0000);
    // secondary reset by bit; configuration stays reachable
    xfer(1'b1, `OFS_BRIDGE_CTL, 32'h0000_0001);
    cyc(2);
    `CHK(srst_n, 1'b0)
    rd_chk(`OFS_STATUS, 32'h0000_0001);
    cyc(30);
    `CHK(srst_n, 1'b0)
    xfer(1'b1, `OFS_BRIDGE_CTL, 32'h0000_0000);
    cyc(2);
    `CHK(srst_n, 1'b1)
    hs_event(1'b1);
    hs_event(1'b0);
    xfer(1'b1, `OFS_HOTSWAP_CTL, 32'h0000_0002);
    cyc(2);
    `CHK(led, 1'b1)
    // unimplemented states leave the power field at zero
    for (int v = 1; v < 3; v++)
    begin
      xfer(1'b1, `OFS_POWER_CTL, 32'(v));
      rd_chk(`OFS_POWER_CTL, 32'h0000_0000);
    end
    xfer(1'b1, `OFS_POWER_CTL, 32'h0000_0003);
    rd_chk(`OFS_STATUS, 32'h0000_000C);
    rd_chk(`OFS_POWER_CTL, 32'h0000_0003);
    repeat (3)
    begin
      cyc(1);
      `CHK(sclk, 5'h00)
    end
    // wake: internal reset without a secondary reset
    xfer(1'b1, `OFS_POWER_CTL, 32'h0000_0000);
    cyc(2);
    `CHK(flush, 1'b1)
    `CHK(doe_n, 1'b1)
    repeat (20)
    begin
      cyc(1);
      `CHK(srst_n, 1'b1)
    end
    clocks_run();
    rd_chk(`OFS_HOTSWAP_CTL, 32'h0000_0000);
    `CHK(led, 1'b0)
    strap <= 1'b0;
    xfer(1'b1, `OFS_POWER_CTL, 32'h0000_0003);
    clocks_run();
    rd_chk(`OFS_STATUS, 32'h0000_0004);
    xfer(1'b1, `OFS_POWER_CTL, 32'h0000_0000);
    // chip reset, then release once the mask is in
    xfer(1'b1, `OFS_BRIDGE_CTL, 32'h0000_0002);
    cyc(2);
    `CHK({poe_n, coe_n, srst_n}, 3'h6)
    `CHK(doe_n, 1'b0)
    rd_chk(`OFS_BRIDGE_CTL, 32'h0000_0003);
    mask_start <= 1'b1;
    cyc(8);
    xfer(1'b1, `OFS_BRIDGE_CTL, 32'h0000_0000);
    t0 = $time;
    do
      xfer(1'b0, `OFS_BRIDGE_CTL, 32'h0000_0000);
    while (rd[1] !== 1'b0 && $time - t0 < 2000);
    `CHK($time - t0 <= 420, 1'b1)
    cyc(2);
    `CHK(srst_n, 1'b1)
    // second reset mid-run from D3hot
    xfer(1'b1, `OFS_POWER_CTL, 32'h0000_0003);
    reset_n_in <= 1'b0;
    cyc(5);
    `CHK({avs_waitrequest_out, poe_n, srst_n}, 3'h6)
    reset_n_in <= 1'b1;
    rd_chk(`OFS_POWER_CTL, 32'h0000_0000);
    tally_and_finish();
  end

  // watchdog against a hang anywhere in the sequence
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    tally_and_finish();
  end
endmodule
